// File: inc/dmc_defs.vh
// register offsets, field positions and fixed codes of the dma channel block
`ifndef DMC_DEFS_VH
`define DMC_DEFS_VH
// per-channel register select, paddr[4:2]
`define DMC_SEL_SRC_LO 3'h0
`define DMC_SEL_SRC_HI 3'h1
`define DMC_SEL_DST_LO 3'h2
`define DMC_SEL_DST_HI 3'h3
`define DMC_SEL_COUNT 3'h4
`define DMC_SEL_ADDRCTL 3'h5
`define DMC_SEL_CHCTL 3'h6
`define DMC_SEL_TRIG 3'h7
// channel_control_reg fields
`define DMC_CC_EN 0
`define DMC_CC_INIT 1
`define DMC_CC_SWTRIG 2
`define DMC_CC_TC 7
// addressing_control_reg fields and writable mask
`define DMC_AC_SIZE16 14
`define DMC_AC_SRC_HI 7
`define DMC_AC_SRC_LO 6
`define DMC_AC_DST_HI 5
`define DMC_AC_DST_LO 4
`define DMC_AC_MASK 16'h40f0
// address high half writable mask, bits 14..10 kept zero
`define DMC_AH_MASK 16'h83ff
// trigger_select_reg fields
`define DMC_TS_PEND 7
// direction codes
`define DMC_DIR_INC 2'h0
`define DMC_DIR_DEC 2'h1
// address bit that tells internal ram from peripheral registers
`define DMC_REGION_BIT 31
`endif

// File: hw/dmc_chan.v
// one dma channel: programmed values, live pointers, enable and flags
`timescale 1ns/1ps
`default_nettype none
`include "dmc_defs.vh"
module dmc_chan (
    input wire mclk,
    input wire reset,
    input wire wr_en,
    input wire [2:0] wr_sel,
    input wire [15:0] wdata,
    input wire rd_ctl,
    input wire hw_req,
    input wire start,
    input wire busy,
    input wire step_src,
    input wire xfer_done,
    output reg [31:0] src_r,
    output reg [31:0] dst_r,
    output reg [15:0] cnt_r,
    output reg [15:0] adc_r,
    output reg [5:0] trig_r,
    output reg en_r,
    output reg tc_r,
    output reg pend_r,
    output reg irq_r,
    output reg init_r
);
    reg [31:0] src_init_r;
    reg [31:0] dst_init_r;
    reg [15:0] cnt_init_r;
    reg sw_r;
    wire [31:0] step;
    wire [1:0] sdir;
    wire [1:0] ddir;
    wire last;
    wire req_evt;

    assign step = adc_r[`DMC_AC_SIZE16] ? 32'h0000_0002 : 32'h0000_0001;
    assign sdir = {adc_r[`DMC_AC_SRC_HI], adc_r[`DMC_AC_SRC_LO]};
    assign ddir = {adc_r[`DMC_AC_DST_HI], adc_r[`DMC_AC_DST_LO]};
    assign last = xfer_done && (cnt_r == 16'h0001);
    // a request while one is held or in service is dropped, not queued
    // nor is one taken as terminal count drops the enable: it would go stale
    assign req_evt = en_r && (hw_req || sw_r) && !pend_r && !busy && !last;

    // register writes, pointer stepping, terminal count and init
    always @(posedge mclk) begin
        if (reset) begin
            src_r <= 32'h0000_0000;
            dst_r <= 32'h0000_0000;
            cnt_r <= 16'h0000;
            src_init_r <= 32'h0000_0000;
            dst_init_r <= 32'h0000_0000;
            cnt_init_r <= 16'h0000;
            adc_r <= 16'h0000;
            trig_r <= 6'h00;
            en_r <= 1'b0;
            tc_r <= 1'b0;
            pend_r <= 1'b0;
            irq_r <= 1'b0;
            init_r <= 1'b0;
            sw_r <= 1'b0;
        end else begin
            irq_r <= last;
            init_r <= 1'b0;
            sw_r <= 1'b0;
            if (start)
                pend_r <= 1'b0;
            else if (req_evt)
                pend_r <= 1'b1;
            // halves move under transfers, so split reads can tear
            if (step_src) begin
                if (sdir == `DMC_DIR_INC)
                    src_r <= src_r + step;
                else if (sdir == `DMC_DIR_DEC)
                    src_r <= src_r - step;
            end
            if (xfer_done) begin
                cnt_r <= cnt_r - 16'h0001;
                if (ddir == `DMC_DIR_INC)
                    dst_r <= dst_r + step;
                else if (ddir == `DMC_DIR_DEC)
                    dst_r <= dst_r - step;
            end
            // read clears the flag, but a fresh terminal count wins
            if (rd_ctl)
                tc_r <= 1'b0;
            if (wr_en) begin
                case (wr_sel)
                    `DMC_SEL_SRC_LO: begin
                        src_r[15:0] <= wdata;
                        src_init_r[15:0] <= wdata;
                    end
                    `DMC_SEL_SRC_HI: begin
                        src_r[31:16] <= wdata & `DMC_AH_MASK;
                        src_init_r[31:16] <= wdata & `DMC_AH_MASK;
                    end
                    `DMC_SEL_DST_LO: begin
                        dst_r[15:0] <= wdata;
                        dst_init_r[15:0] <= wdata;
                    end
                    `DMC_SEL_DST_HI: begin
                        dst_r[31:16] <= wdata & `DMC_AH_MASK;
                        dst_init_r[31:16] <= wdata & `DMC_AH_MASK;
                    end
                    `DMC_SEL_COUNT: begin
                        cnt_r <= wdata;
                        cnt_init_r <= wdata;
                    end
                    `DMC_SEL_ADDRCTL: adc_r <= wdata & `DMC_AC_MASK;
                    `DMC_SEL_CHCTL: begin
                        en_r <= wdata[`DMC_CC_EN];
                        sw_r <= wdata[`DMC_CC_SWTRIG];
                        if (wdata[`DMC_CC_INIT]) begin
                            // reload and drop the unfinished sequence
                            init_r <= 1'b1;
                            src_r <= src_init_r;
                            dst_r <= dst_init_r;
                            cnt_r <= cnt_init_r;
                            pend_r <= 1'b0;
                        end
                    end
                    `DMC_SEL_TRIG: trig_r <= wdata[5:0];
                    default: ;
                endcase
            end
            if (last) begin
                en_r <= 1'b0;
                tc_r <= 1'b1;
            end
        end
    end
endmodule // dmc_chan
`default_nettype wire

// File: hw/dmc_top.v
// four-channel dma controller with apb registers and internal bus master
// Overview of operation
// - terminal count flag clears when read
// - count reads initial value after init
// - per-channel pending request flag readable
// - enable clear pauses, set resumes transfers
// - odd address lsb forced zero on 16-bit transfers
// - dma beats cpu on shared target
// - cpu free on untouched target
// - address halves update live, may tear
// - terminal count clears enable, flags, interrupts
`timescale 1ns/1ps
`default_nettype none
`include "dmc_defs.vh"
module dmc_top #(
    parameter NCH = 4,
    parameter NTRIG = 64
) (
    input wire mclk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [NTRIG-1:0] trig_in,
    output reg mbus_req,
    output reg mbus_we,
    output reg mbus_size16,
    output reg [31:0] mbus_addr,
    output reg [15:0] mbus_wdata,
    input wire [15:0] mbus_rdata,
    input wire mbus_ack,
    input wire cpu_req,
    input wire [31:0] cpu_addr,
    output reg cpu_gnt,
    output wire [NCH-1:0] transfer_end_irq
);
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_RD = 4'b0010;
    localparam [3:0] S_GAP = 4'b0100;
    localparam [3:0] S_WR = 4'b1000;

    reg [3:0] state_r;
    reg [1:0] cur_r;
    reg [15:0] data_r;
    reg [NCH-1:0] start_r;
    reg [NCH-1:0] stepsrc_r;
    reg [NCH-1:0] done_r;
    reg [31:0] prdata_nxt;
    reg hit;
    reg [1:0] pick;
    reg pick_ok;
    integer k;

    wire [32*NCH-1:0] src_v;
    wire [32*NCH-1:0] dst_v;
    wire [16*NCH-1:0] cnt_v;
    wire [16*NCH-1:0] adc_v;
    wire [6*NCH-1:0] trig_v;
    wire [NCH-1:0] en_v;
    wire [NCH-1:0] tc_v;
    wire [NCH-1:0] pend_v;
    wire [NCH-1:0] init_v;
    wire [NCH-1:0] hw_req;
    wire [NCH-1:0] wr_en;
    wire [NCH-1:0] rd_ctl;
    wire [NCH-1:0] busy;

    // access edge: both strobes and our own pready high
    wire acc = psel && penable && pready;
    wire [1:0] pch = paddr[6:5];
    wire [2:0] psel_reg = paddr[4:2];
    wire mapped = !paddr[7] && (paddr[1:0] == 2'b00);
    wire [15:0] cur_adc = adc_v[cur_r*16 +: 16];
    wire cur_sz = cur_adc[`DMC_AC_SIZE16];
    wire [31:0] cur_src = src_v[cur_r*32 +: 32];
    wire [31:0] cur_dst = dst_v[cur_r*32 +: 32];

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            assign hw_req[g] = trig_in[trig_v[g*6 +: 6]];
            assign wr_en[g] = acc && pwrite && mapped && (pch == g);
            assign rd_ctl[g] = acc && !pwrite && mapped && (pch == g) &&
                (psel_reg == `DMC_SEL_CHCTL);
            assign busy[g] = !state_r[0] && (cur_r == g);
            dmc_chan u_chan (
                .mclk(mclk),
                .reset(reset),
                .wr_en(wr_en[g]),
                .wr_sel(psel_reg),
                .wdata(pwdata[15:0]),
                .rd_ctl(rd_ctl[g]),
                .hw_req(hw_req[g]),
                .start(start_r[g]),
                .busy(busy[g]),
                .step_src(stepsrc_r[g]),
                .xfer_done(done_r[g]),
                .src_r(src_v[g*32 +: 32]),
                .dst_r(dst_v[g*32 +: 32]),
                .cnt_r(cnt_v[g*16 +: 16]),
                .adc_r(adc_v[g*16 +: 16]),
                .trig_r(trig_v[g*6 +: 6]),
                .en_r(en_v[g]),
                .tc_r(tc_v[g]),
                .pend_r(pend_v[g]),
                .irq_r(transfer_end_irq[g]),
                .init_r(init_v[g])
            );
        end
    endgenerate

    // read mux; halves read separately so a transfer may split them
    always @* begin
        prdata_nxt = 32'h0000_0000;
        hit = mapped;
        case (psel_reg)
            `DMC_SEL_SRC_LO: prdata_nxt[15:0] = src_v[pch*32 +: 16];
            `DMC_SEL_SRC_HI: prdata_nxt[15:0] = src_v[pch*32+16 +: 16];
            `DMC_SEL_DST_LO: prdata_nxt[15:0] = dst_v[pch*32 +: 16];
            `DMC_SEL_DST_HI: prdata_nxt[15:0] = dst_v[pch*32+16 +: 16];
            `DMC_SEL_COUNT: prdata_nxt[15:0] = cnt_v[pch*16 +: 16];
            `DMC_SEL_ADDRCTL: prdata_nxt[15:0] = adc_v[pch*16 +: 16];
            `DMC_SEL_CHCTL: begin
                prdata_nxt[`DMC_CC_EN] = en_v[pch];
                prdata_nxt[`DMC_CC_TC] = tc_v[pch];
            end
            `DMC_SEL_TRIG: begin
                prdata_nxt[5:0] = trig_v[pch*6 +: 6];
                prdata_nxt[`DMC_TS_PEND] = pend_v[pch];
            end
            default: hit = 1'b0;
        endcase
        if (!hit)
            prdata_nxt = 32'h0000_0000;
    end

    // apb answer: one wait state, then pready for exactly one cycle
    always @(posedge mclk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit;
            if (psel && penable && !pready && !pwrite)
                prdata <= prdata_nxt;
        end
    end

    // fixed priority, channel 0 highest, checked before every transfer
    always @* begin
        pick = 2'd0;
        pick_ok = 1'b0;
        for (k = NCH - 1; k >= 0; k = k - 1) begin
            if (pend_v[k] && en_v[k]) begin
                pick = k[1:0];
                pick_ok = 1'b1;
            end
        end
    end

    // two-cycle transfer engine: read, one idle clock, write
    always @(posedge mclk) begin
        if (reset) begin
            state_r <= S_IDLE;
            cur_r <= 2'd0;
            data_r <= 16'h0000;
            start_r <= {NCH{1'b0}};
            stepsrc_r <= {NCH{1'b0}};
            done_r <= {NCH{1'b0}};
            mbus_req <= 1'b0;
            mbus_we <= 1'b0;
            mbus_size16 <= 1'b0;
            mbus_addr <= 32'h0000_0000;
            mbus_wdata <= 16'h0000;
        end else begin
            start_r <= {NCH{1'b0}};
            stepsrc_r <= {NCH{1'b0}};
            done_r <= {NCH{1'b0}};
            case (state_r)
                S_IDLE: begin
                    // a cleared enable holds the request back
                    if (pick_ok) begin
                        cur_r <= pick;
                        start_r[pick] <= 1'b1;
                        state_r <= S_RD;
                    end
                end
                S_RD: begin
                    mbus_req <= !mbus_ack;
                    mbus_we <= 1'b0;
                    mbus_size16 <= cur_sz;
                    // odd address on a 16-bit transfer loses its lsb
                    mbus_addr <= {cur_src[31:1], cur_src[0] & !cur_sz};
                    if (mbus_req && mbus_ack) begin
                        data_r <= mbus_rdata;
                        stepsrc_r[cur_r] <= 1'b1;
                        state_r <= S_GAP;
                    end
                end
                S_GAP: begin
                    mbus_req <= 1'b1;
                    mbus_we <= 1'b1;
                    mbus_addr <= {cur_dst[31:1], cur_dst[0] & !cur_sz};
                    mbus_wdata <= data_r;
                    state_r <= S_WR;
                end
                S_WR: begin
                    if (mbus_ack) begin
                        mbus_req <= 1'b0;
                        done_r[cur_r] <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
            // init on the active channel drops the sequence at once
            if (!state_r[0] && init_v[cur_r]) begin
                mbus_req <= 1'b0;
                state_r <= S_IDLE;
            end
        end
    end

    // cpu waits only when it targets the region the dma cycle holds
    always @(posedge mclk) begin
        if (reset)
            cpu_gnt <= 1'b0;
        else
            cpu_gnt <= cpu_req && !(!state_r[0] && !state_r[1] &&
                (cpu_addr[`DMC_REGION_BIT] ==
                 mbus_addr[`DMC_REGION_BIT])) && !(state_r[1] &&
                (cpu_addr[`DMC_REGION_BIT] ==
                 cur_src[`DMC_REGION_BIT]));
    end
endmodule // dmc_top
`default_nettype wire

// File: verif/dmc_top_asserts.sv
// concurrent checks on the dma controller top-level ports
`timescale 1ns/1ps
`default_nettype none
module dmc_top_asserts #(
    parameter NCH = 4
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mbus_req,
    input wire logic mbus_we,
    input wire logic mbus_size16,
    input wire logic [31:0] mbus_addr,
    input wire logic mbus_ack,
    input wire logic cpu_req,
    input wire logic [31:0] cpu_addr,
    input wire logic cpu_gnt,
    input wire logic [NCH-1:0] transfer_end_irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    // bus phases the properties are built from
    sequence s_apb_start;
        psel && $rose(penable);
    endsequence
    sequence s_rd_done;
        mbus_req && mbus_ack && !mbus_we;
    endsequence
    sequence s_same_region;
        cpu_req && mbus_req && mbus_addr[31] == cpu_addr[31];
    endsequence
    sequence s_other_region;
        cpu_req && mbus_req && mbus_addr[31] != cpu_addr[31];
    endsequence
    chk_pready_late: assert property (s_apb_start |=> pready)
        else $error("pready missing in second access cycle");
    chk_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_slverr_map: assert property (
        pready |-> pslverr == (paddr[7] || paddr[1:0] != 2'h0))
        else $error("pslverr does not match address map");
    chk_addr_even: assert property (mbus_req && mbus_size16 |-> !mbus_addr[0])
        else $error("odd address on 16-bit dma access");
    chk_read_gap: assert property (s_rd_done |=> !mbus_req)
        else $error("no idle cycle after dma read");
    chk_irq_after_wr: assert property (
        |transfer_end_irq |-> $past(mbus_ack && mbus_we)
        || $past(mbus_ack && mbus_we, 2))
        else $error("transfer end without write completion");
    chk_irq_pulse: assert property ((transfer_end_irq & $past(transfer_end_irq)) == '0)
        else $error("transfer end request longer than one cycle");
    chk_cpu_stall: assert property (s_same_region |=> !cpu_gnt)
        else $error("cpu granted during dma cycle on its region");
    chk_cpu_free: assert property (s_other_region [*2] |-> cpu_gnt)
        else $error("cpu held off on untouched region");
endmodule // dmc_top_asserts
bind dmc_top dmc_top_asserts #(.NCH(NCH)) i_dmc_top_asserts (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .mbus_req(mbus_req), .mbus_we(mbus_we), .mbus_size16(mbus_size16),
    .mbus_addr(mbus_addr), .mbus_ack(mbus_ack), .cpu_req(cpu_req),
    .cpu_addr(cpu_addr), .cpu_gnt(cpu_gnt),
    .transfer_end_irq(transfer_end_irq));
`default_nettype wire

// File: verif/dmc_mem_model.sv
// ram and peripheral target model answering the dma bus master
`timescale 1ns/1ps
`default_nettype none
module dmc_mem_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic mbus_req,
    input wire logic mbus_we,
    input wire logic [31:0] mbus_addr,
    input wire logic [15:0] mbus_wdata,
    output logic [15:0] mbus_rdata,
    output logic mbus_ack,
    output logic [31:0] last_waddr,
    output logic [15:0] last_wdata
);
    logic [1:0] wait_r;
    // ack after 0..2 wait states, drawn at random at every ack
    // read data scrambles outside acks so a late sample shows up
    always @(posedge mclk) begin
        if (reset) begin
            mbus_ack <= 1'b0;
            mbus_rdata <= 16'h0000;
            wait_r <= 2'h0;
            last_waddr <= 32'h0000_0000;
            last_wdata <= 16'h0000;
        end else if (mbus_req && !mbus_ack && wait_r == 2'h0) begin
            mbus_ack <= 1'b1;
            mbus_rdata <= mbus_addr[15:0] ^ 16'ha5a5;
            wait_r <= 2'($urandom_range(2));
            if (mbus_we) begin
                last_waddr <= mbus_addr;
                last_wdata <= mbus_wdata;
            end
        end else begin
            mbus_ack <= 1'b0;
            mbus_rdata <= ~mbus_rdata;
            if (mbus_req && !mbus_ack)
                wait_r <= wait_r - 2'h1;
        end
    end
endmodule // dmc_mem_model
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the four-channel dma controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic cpu_req = 0, mbus_req, mbus_we, mbus_ack, pready, pslverr, cpu_gnt;
    logic [7:0] paddr = 0, a;
    logic [31:0] pwdata = 0, cpu_addr = 0, prdata, mbus_addr, rd, src, dst;
    logic [31:0] last_waddr;
    logic [63:0] trig_in = 0;
    logic [15:0] mbus_wdata, mbus_rdata, last_wdata;
    logic [3:0] irq;
    logic mbus_size16, err;
    int mismatches = 0, n_compared = 0, n_irq = 0, n_wr = 0, m, k, t;
    dmc_top i_dmc_top (.mclk(mclk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trig_in(trig_in), .mbus_req(mbus_req), .mbus_we(mbus_we),
        .mbus_size16(mbus_size16), .mbus_addr(mbus_addr),
        .mbus_wdata(mbus_wdata), .mbus_rdata(mbus_rdata),
        .mbus_ack(mbus_ack), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
        .cpu_gnt(cpu_gnt), .transfer_end_irq(irq));
    dmc_mem_model i_dmc_mem_model (.mclk(mclk), .reset(reset),
        .mbus_req(mbus_req), .mbus_we(mbus_we), .mbus_addr(mbus_addr),
        .mbus_wdata(mbus_wdata), .mbus_rdata(mbus_rdata),
        .mbus_ack(mbus_ack), .last_waddr(last_waddr),
        .last_wdata(last_wdata));
    always #4 mclk = ~mclk;
    // counts completions so waits need no exact latency
    always @(posedge mclk) begin
        n_irq <= n_irq + $countones(irq);
        n_wr <= n_wr + int'(mbus_req && mbus_ack && mbus_we);
    end
    // copy of a source word as the target model hands it out
    function logic [15:0] exp_data(input logic [31:0] s);
        return (s[15:0] & 16'hfffe) ^ 16'ha5a5;
    endfunction
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int j;
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        j = 0;
        do begin @(posedge mclk); j++; end while (pready !== 1'b1 && j < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (j == 16) begin mismatches++; summarize(); end
    endtask
    // bounded wait on a completion counter
    task automatic wait_for(ref int cnt, input int target);
        k = 0;
        while (cnt < target && k < 200) begin @(posedge mclk); k++; end
        if (cnt < target) begin mismatches++; summarize(); end
    endtask
    initial begin
        void'($urandom(25));
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        // reserved bits of addressing control are written as zero
        apb(1, 8'h14, 32'h0000_40f0);
        apb(0, 8'h14, 32'h0000_0000);
        `CHK(rd, 32'h0000_40f0)
        `CHK(err, 1'b0)
        apb(1, 8'h82, 32'h0000_0001);
        `CHK(err, 1'b1)
        apb(0, 8'h1c, 32'h0000_0000);
        `CHK(rd[7], 1'b0)
        // single copy per channel, odd addresses, cpu on a random region
        for (int ch = 0; ch < 4; ch++) begin
            a = 8'(ch * 32);
            src = ($urandom & 32'h83ff_ffff) | 32'h0000_0001;
            dst = ($urandom & 32'h03ff_ffff) | (src & 32'h8000_0000) |
                32'h0000_0001;
            cpu_req <= 1'b1;
            cpu_addr <= $urandom & 32'hffff_fffc;
            apb(1, a, {16'h0000, src[15:0]});
            apb(1, a + 8'h04, {16'h0000, src[31:16]});
            apb(1, a + 8'h08, {16'h0000, dst[15:0]});
            apb(1, a + 8'h0c, {16'h0000, dst[31:16]});
            apb(1, a + 8'h10, 32'h0000_0001);
            apb(1, a + 8'h14, 32'h0000_4000);
            apb(1, a + 8'h18, 32'h0000_0005);
            wait_for(n_irq, ch + 1);
            `CHK(last_waddr, {dst[31:1], 1'b0})
            `CHK(last_wdata, exp_data(src))
            apb(0, a + 8'h18, 32'h0000_0000);
            `CHK(rd[7:0] & 8'h81, 8'h80)
            // flag seen set, so three more reads make sure it clears
            repeat (3) begin
                apb(0, a + 8'h18, 32'h0000_0000);
                `CHK(rd[7], 1'b0)
            end
            apb(0, a + 8'h10, 32'h0000_0000);
            `CHK(rd, 32'h0000_0000)
        end
        repeat (3) @(posedge mclk);
        `CHK(cpu_gnt, 1'b1)
        // trigger while disabled does nothing, enabling with a fresh trigger copies
        apb(1, 8'h10, 32'h0000_0002);
        m = n_wr;
        apb(1, 8'h18, 32'h0000_0004);
        repeat (20) @(posedge mclk);
        `CHK(n_wr, m)
        apb(1, 8'h18, 32'h0000_0005);
        wait_for(n_wr, m + 1);
        apb(0, 8'h10, 32'h0000_0000);
        `CHK(rd, 32'h0000_0001)
        // no request held, then stop all channels, target cleared again
        apb(0, 8'h1c, 32'h0000_0000);
        `CHK(rd[7], 1'b0)
        for (int c = 3; c >= 0; c--)
            apb(1, 8'(c * 32 + 24), 32'h0000_0000);
        repeat (2) apb(1, 8'h18, 32'h0000_0000);
        // init on channel 0 reloads its count to the programmed value
        apb(1, 8'h18, 32'h0000_0002);
        apb(0, 8'h10, 32'h0000_0000);
        `CHK(rd, 32'h0000_0002)
        // init with a transfer in flight abandons it
        apb(1, 8'h18, 32'h0000_0005);
        apb(1, 8'h18, 32'h0000_0002);
        m = n_wr;
        apb(0, 8'h10, 32'h0000_0000);
        `CHK(rd, 32'h0000_0002)
        repeat (12) @(posedge mclk);
        `CHK(n_wr, m)
        // hardware trigger on channel 1, a line no other channel starts on
        t = 1 + $urandom_range(62);
        apb(1, 8'h3c, 32'(t));
        apb(1, 8'h30, 32'h0000_0001);
        apb(1, 8'h38, 32'h0000_0001);
        m = n_wr;
        trig_in[t] <= 1'b1;
        @(posedge mclk);
        trig_in <= 64'h0;
        wait_for(n_wr, m + 1);
        apb(0, 8'h3c, 32'h0000_0000);
        `CHK(rd, 32'(t))
        apb(0, 8'h30, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        `CHK(n_irq, 5)
        summarize();
    end
endmodule // tb_top
`default_nettype wire
